// ==== lcd_ram_pkg.sv ====
/*
  Shared constants of the display-memory core: register offsets,
  field positions, reset values, drive modes and frame divisors.
  Assumes an APB register bus with 32-bit data and byte addresses.
*/
`default_nettype none

package lcd_ram_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CtrlOffs = 8'h00;
  localparam logic [7:0] PtrOffs = 8'h04;
  localparam logic [7:0] SubOffs = 8'h08;
  localparam logic [7:0] DataOffs = 8'h0C;
  localparam logic [7:0] StatOffs = 8'h10;
  localparam logic [7:0] RamBase = 8'h40;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CtrlModeLsb = 0;
  localparam int CtrlOnBit = 2;
  localparam int CtrlSaveBit = 3;
  localparam int CtrlRateLsb = 4;
  localparam int CtrlAltBit = 6;
  localparam int CtrlInBankBit = 7;
  localparam int CtrlOutBankBit = 8;
  localparam int CtrlWidth = 9;
  localparam logic [8:0] CtrlReset = 9'h000;

  // ----------------------------------------
  // Memory shape and frame divisors
  // ----------------------------------------
  localparam int NumWords = 40;
  localparam logic [5:0] LastAddr = 6'h27;
  localparam int DivWidth = 18;
  localparam logic [17:0] FrameNormal = 18'h0_0B40;
  localparam logic [17:0] FrameSave = 18'h0_01E0;

  typedef enum logic [1:0] {modeStatic, modeMux2, modeMux3, modeMux4} driveMode_e;
  typedef enum logic {storeIdle, storeBusy} store_e;

endpackage

`default_nettype wire

// ==== div_if.sv ====
/*
  Divider carrier: a divisor handed to a counter and its tick back.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface div_if #(parameter int W = 18);
  logic [W-1:0] divisor;
  logic tick;
  modport ctl (output divisor, input tick);
  modport cnt (input divisor, output tick);
endinterface

`default_nettype wire

// ==== rate_div.sv ====
/*
  Free-running divider: one tick every divisor clocks.
  Assumes a divisor of at least one; a new divisor takes effect at once.
*/
`timescale 1ns/1ns
`default_nettype none

module rate_div #(parameter int W = 18)
(
  input wire logic clk,
  input wire logic resetn,
  div_if.cnt port
);

  logic [W-1:0] count_q;

  assign port.tick = (count_q >= port.divisor - W'(1));

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_q <= '0;
    else if (port.tick)
      count_q <= '0;
    else
      count_q <= count_q + W'(1);
  end

endmodule

`default_nettype wire

// ==== pin_sync.sv ====
/*
  Pin synchroniser: four flip-flops per bit; the output follows
  once the second and third stages agree.
  Assumes asynchronous, slowly changing strap pins.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(parameter int W = 3)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] value
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] value_q;

  assign value = value_q;

  // ----------------------------------------
  // Stages and agreement
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      value_q <= '0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
          value_q[i] <= s3_q[i];
      end
    end
  end

endmodule

`default_nettype wire

// ==== lcd_display_ram.sv ====
/*
  Display memory core: 40 x 4-bit RAM, byte placement by drive mode,
  auto-advancing write pointer, cascade subaddress counter, input and
  output bank selection, frame and rate_cmd_a timing, APB register slave.
  Assumes an APB master on clk and strap pins held steady in use.
*/
// The APB register port and the register addresses were decided locally.
//
// Behaviour
// - 40 words of 4 bits, 1 is on
// - Address is segment, bit is backplane
// - Static: byte into bit 0, eight addresses
// - 1:2: byte into bits 0-1, four addresses
// - 1:3: three addresses, last bit 2 kept
// - 1:4: byte into bits 0-3, two addresses
// - Frame is clock/2880, or /480 saving
// - Pointer write first, bytes store from pointer
// - Pointer advances 8, 4, 3 or 2
// - Store only when subaddress counter matches pins
// - Subaddress command loads the counter
// - Mismatch discards byte, pointer still advances
// - Pointer overflow increments subaddress counter
// - Output bank scans rows in multiplex order
// - Static: display may use bit 2
// - 1:2: display may use bits 2-3
// - Input bank redirects writes to upper bits in static, 1:2 only
// - Input and output banks held separately
// - Rate_cmd_a off, 2, 1, 0.5 Hz divisors
// - Power-saving rate_cmd_a divisors 15360, 30720, 61440
// - Alternate-bank rate_cmd_a in static, 1:2 only
// - Display-on bit blanks and restores display
// - Busy store stalls the next write
`timescale 1ns/1ns
`default_nettype none

module lcd_display_ram #(
  parameter int unsigned RATE_CMD_A_NORM_2HZ = 32'h0001_6800,
  parameter int unsigned RATE_CMD_A_NORM_1HZ = 32'h0002_D000,
  parameter int unsigned RATE_CMD_A_NORM_HALF = 32'h0005_A000,
  parameter int unsigned RATE_CMD_A_SAVE_2HZ = 32'h0000_3C00,
  parameter int unsigned RATE_CMD_A_SAVE_1HZ = 32'h0000_7800,
  parameter int unsigned RATE_CMD_A_SAVE_HALF = 32'h0000_F000
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_subaddr_pin0,
  input wire logic hw_subaddr_pin1,
  input wire logic hw_subaddr_pin2,
  output logic [39:0] segment,
  output logic [3:0] backplane
);

  localparam int W = lcd_ram_pkg::DivWidth;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (RATE_CMD_A_NORM_2HZ < 2 || RATE_CMD_A_NORM_1HZ < 2 || RATE_CMD_A_NORM_HALF < 2
      || RATE_CMD_A_SAVE_2HZ < 2 || RATE_CMD_A_SAVE_1HZ < 2 || RATE_CMD_A_SAVE_HALF < 2
      || RATE_CMD_A_NORM_HALF / 2 >= (1 << W))
  begin : badBlinkDivisor
    $error("Rate_cmd_a divisors must be at least 2 and fit the divider");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [lcd_ram_pkg::CtrlWidth-1:0] ctrl_q;
  logic [5:0] ptr_q;
  logic [2:0] subCnt_q;
  logic [3:0] ram_q [lcd_ram_pkg::NumWords];
  logic [7:0] shift_q;
  logic [2:0] left_q;
  logic [1:0] pos_q;
  lcd_ram_pkg::store_e store_q;
  logic [1:0] row_q;
  logic blinkPhase_q;
  logic [39:0] segment_q;
  logic [3:0] backplane_q;
  logic [31:0] prdata_q;
  logic [2:0] strap;

  lcd_ram_pkg::driveMode_e mode;
  logic displayOn;
  logic powerSave;
  logic [1:0] rate;
  logic altBlink;
  logic inBank;
  logic outBank;
  logic lowModes;
  logic busy;
  logic subMatch;
  logic advance;
  logic [1:0] inBit;
  logic [1:0] outBit;
  logic bankSwap;
  logic blanked;

  assign mode = lcd_ram_pkg::driveMode_e'(ctrl_q[lcd_ram_pkg::CtrlModeLsb +: 2]);
  assign displayOn = ctrl_q[lcd_ram_pkg::CtrlOnBit];
  assign powerSave = ctrl_q[lcd_ram_pkg::CtrlSaveBit];
  assign rate = ctrl_q[lcd_ram_pkg::CtrlRateLsb +: 2];
  assign altBlink = ctrl_q[lcd_ram_pkg::CtrlAltBit];
  assign inBank = ctrl_q[lcd_ram_pkg::CtrlInBankBit];
  assign outBank = ctrl_q[lcd_ram_pkg::CtrlOutBankBit];
  assign lowModes = (mode == lcd_ram_pkg::modeStatic) || (mode == lcd_ram_pkg::modeMux2);
  assign busy = (store_q == lcd_ram_pkg::storeBusy);

  // ----------------------------------------
  // Strap pins
  // ----------------------------------------
  pin_sync #(.W(3)) strapSync (
    .clk(clk),
    .resetn(resetn),
    .pins({hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0}),
    .value(strap)
  );

  assign subMatch = (subCnt_q == strap);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic access;
  logic wrEn;
  logic mapped;
  logic ramHit;
  logic [7:0] ramOffs;
  logic [5:0] ramIdx;

  assign access = psel && penable;
  assign pready = !(psel && pwrite && busy);
  assign wrEn = access && pwrite && pready && !pslverr;
  assign ramOffs = paddr - lcd_ram_pkg::RamBase;
  assign ramIdx = ramOffs[7:2];
  assign ramHit = (paddr >= lcd_ram_pkg::RamBase) && (ramOffs[1:0] == 2'h0)
    && (ramIdx <= lcd_ram_pkg::LastAddr) && !pwrite;
  assign mapped = ramHit
    || (paddr == lcd_ram_pkg::CtrlOffs) || (paddr == lcd_ram_pkg::PtrOffs)
    || (paddr == lcd_ram_pkg::SubOffs) || (paddr == lcd_ram_pkg::StatOffs && !pwrite)
    || (paddr == lcd_ram_pkg::DataOffs && pwrite);
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata_q <= '0;
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= '0;
      if (ramHit)
        prdata_q <= {28'h000_0000, ram_q[ramIdx]};
      else if (paddr == lcd_ram_pkg::CtrlOffs)
        prdata_q <= {23'h00_0000, ctrl_q};
      else if (paddr == lcd_ram_pkg::PtrOffs)
        prdata_q <= {26'h000_0000, ptr_q};
      else if (paddr == lcd_ram_pkg::SubOffs)
        prdata_q <= {29'h000_0000, subCnt_q};
      else if (paddr == lcd_ram_pkg::StatOffs)
        prdata_q <= {21'h00_0000, busy, subMatch, blinkPhase_q, row_q, subCnt_q, strap};
    end
  end

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_q <= lcd_ram_pkg::CtrlReset;
    else if (wrEn && paddr == lcd_ram_pkg::CtrlOffs)
      ctrl_q <= pwdata[lcd_ram_pkg::CtrlWidth-1:0];
  end

  // ----------------------------------------
  // Store engine
  // ----------------------------------------
  assign advance = busy && (pos_q == 2'(mode) || left_q == 3'h0);
  assign inBit = pos_q + ((inBank && lowModes) ? 2'h2 : 2'h0);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      store_q <= lcd_ram_pkg::storeIdle;
      shift_q <= '0;
      left_q <= '0;
      pos_q <= '0;
    end
    else
    begin
      unique case (store_q)
        lcd_ram_pkg::storeIdle:
        begin
          if (wrEn && paddr == lcd_ram_pkg::DataOffs)
          begin
            shift_q <= pwdata[7:0];
            left_q <= 3'h7;
            pos_q <= '0;
            store_q <= lcd_ram_pkg::storeBusy;
          end
        end
        lcd_ram_pkg::storeBusy:
        begin
          shift_q <= {shift_q[6:0], 1'b0};
          left_q <= left_q - 3'h1;
          pos_q <= advance ? 2'h0 : pos_q + 2'h1;
          if (left_q == 3'h0)
            store_q <= lcd_ram_pkg::storeIdle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < lcd_ram_pkg::NumWords; i++)
        ram_q[i] <= 4'h0;
    end
    else if (busy && subMatch && ptr_q <= lcd_ram_pkg::LastAddr)
      ram_q[ptr_q][inBit] <= shift_q[7];
  end

  // ----------------------------------------
  // Pointer and subaddress counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ptr_q <= '0;
      subCnt_q <= '0;
    end
    else if (advance)
    begin
      if (ptr_q >= lcd_ram_pkg::LastAddr)
      begin
        ptr_q <= '0;
        subCnt_q <= subCnt_q + 3'h1;
      end
      else
        ptr_q <= ptr_q + 6'h01;
    end
    else if (wrEn && paddr == lcd_ram_pkg::PtrOffs)
      ptr_q <= pwdata[5:0];
    else if (wrEn && paddr == lcd_ram_pkg::SubOffs)
      subCnt_q <= pwdata[2:0];
  end

  // ----------------------------------------
  // Frame and rate_cmd_a timing
  // ----------------------------------------
  div_if #(.W(W)) frameDiv ();
  div_if #(.W(W)) blinkDiv ();
  logic [W-1:0] frameBase;

  rate_div #(.W(W)) frameCounter (.clk(clk), .resetn(resetn), .port(frameDiv.cnt));
  rate_div #(.W(W)) blinkCounter (.clk(clk), .resetn(resetn), .port(blinkDiv.cnt));

  assign frameBase = powerSave ? lcd_ram_pkg::FrameSave : lcd_ram_pkg::FrameNormal;

  always_comb
  begin
    unique case (mode)
      lcd_ram_pkg::modeStatic: frameDiv.divisor = frameBase;
      lcd_ram_pkg::modeMux2: frameDiv.divisor = W'(frameBase / 2);
      lcd_ram_pkg::modeMux3: frameDiv.divisor = W'(frameBase / 3);
      lcd_ram_pkg::modeMux4: frameDiv.divisor = W'(frameBase / 4);
    endcase
  end

  always_comb
  begin
    unique case (rate)
      2'h1: blinkDiv.divisor = W'((powerSave ? RATE_CMD_A_SAVE_2HZ : RATE_CMD_A_NORM_2HZ) / 2);
      2'h2: blinkDiv.divisor = W'((powerSave ? RATE_CMD_A_SAVE_1HZ : RATE_CMD_A_NORM_1HZ) / 2);
      2'h3: blinkDiv.divisor = W'((powerSave ? RATE_CMD_A_SAVE_HALF : RATE_CMD_A_NORM_HALF) / 2);
      2'h0: blinkDiv.divisor = W'(RATE_CMD_A_NORM_2HZ / 2);
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      blinkPhase_q <= 1'b0;
    else if (rate == 2'h0)
      blinkPhase_q <= 1'b0;
    else if (blinkDiv.tick)
      blinkPhase_q <= !blinkPhase_q;
  end

  // ----------------------------------------
  // Output bank selector
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      row_q <= '0;
    else if (row_q > 2'(mode))
      row_q <= '0;
    else if (frameDiv.tick)
      row_q <= (row_q == 2'(mode)) ? 2'h0 : row_q + 2'h1;
  end

  assign bankSwap = altBlink && lowModes && blinkPhase_q;
  assign blanked = !displayOn || (blinkPhase_q && !(altBlink && lowModes));
  assign outBit = row_q + (((outBank ^ bankSwap) && lowModes) ? 2'h2 : 2'h0);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      segment_q <= '0;
      backplane_q <= '0;
    end
    else
    begin
      for (int i = 0; i < lcd_ram_pkg::NumWords; i++)
        segment_q[i] <= !blanked && ram_q[i][outBit];
      backplane_q <= 4'h1 << row_q;
    end
  end

  assign segment = segment_q;
  assign backplane = backplane_q;

endmodule

`default_nettype wire

// ==== lcd_display_ram_properties.sv ====
/*
  Port checker for the display memory core: bus answers and row scan.
  Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module lcd_display_ram_properties
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] backplane
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_idle_ready: assert property (!psel |-> pready)
    else $error("ready low while idle");
  a_stall_write: assert property (!pready |-> psel && pwrite)
    else $error("stall without a write");
  a_stall_bound: assert property (!pready |-> ##[1:9] pready)
    else $error("stall too long");
  a_err_unmapped: assert property (psel && penable && paddr == 8'h14 |-> pslverr)
    else $error("unmapped access accepted");
  a_err_ramwrite: assert property (psel && penable && pwrite && paddr[7:6] == 2'h1 |-> pslverr)
    else $error("memory window write accepted");
  a_ok_ptr: assert property (psel && penable && paddr == 8'h04 |-> !pslverr)
    else $error("pointer access refused");
  a_row_onehot: assert property ($past(resetn) |-> $onehot(backplane))
    else $error("row select not one-hot");
  a_row_rotate: assert property ($changed(backplane) && $past(resetn) |->
    backplane == 4'h1 || backplane == {$past(backplane[2:0]), 1'h0})
    else $error("row order broken");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
endmodule

bind lcd_display_ram lcd_display_ram_properties lcd_display_ram_properties_inst (.clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .backplane);

`default_nettype wire

// ==== apb_host.sv ====
/*
  Host model: APB master issuing one transfer per call.
  Assumes the caller is right after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module apb_host
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------
  // Transfer
  // ----------------------------------------
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~d;
  endtask
endmodule

`default_nettype wire

// ==== lcd_display_ram_bench.sv ====
/*
  Self-checking bench of the display memory core.
  Assumes the host model and the checker files compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module lcd_display_ram_bench;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] segment;
  logic [3:0] backplane;
  logic [2:0] strap = 3'h0;
  logic [3:0] old [8];
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int m, n, ofs, p;

  always #5 clk = ~clk;

  lcd_display_ram #(.RATE_CMD_A_NORM_2HZ(16), .RATE_CMD_A_NORM_1HZ(32), .RATE_CMD_A_NORM_HALF(64),
    .RATE_CMD_A_SAVE_1HZ(24), .RATE_CMD_A_SAVE_HALF(48))
  lcd_display_ram_inst (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hw_subaddr_pin0(strap[0]), .hw_subaddr_pin1(strap[1]),
    .hw_subaddr_pin2(strap[2]), .segment, .backplane);

  apb_host apb_host_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_inst.xfer(1'h1, a, d, rd, err);
  endtask

  task automatic rdw(input logic [7:0] a);
    apb_host_inst.xfer(1'h0, a, 32'h0000_0000, rd, err);
  endtask

  // Polls the busy flag until a byte store has finished
  task automatic drain;
    rdw(lcd_ram_pkg::StatOffs);
    while (rd[10] !== 1'h0)
      rdw(lcd_ram_pkg::StatOffs);
  endtask

  // Half rate_cmd_a period: bench divisors, power-saving 2 Hz at its own value
  function automatic int half_period(input int r, input int s);
    if (s != 0)
      return (r == 1) ? 15360 / 2 : 6 << (r - 1);
    return 8 << (r - 1);
  endfunction

  function automatic logic [7:0] watch(input int sel);
    return (sel != 0) ? segment[7:0] : {4'h0, backplane};
  endfunction

  task automatic dwell(input int sel, input int exp);
    logic [7:0] v;
    int t;
    t = 0;
    repeat (2) @(posedge clk);
    v = watch(sel);
    while (watch(sel) === v)
      @(posedge clk);
    v = watch(sel);
    while (watch(sel) === v)
    begin
      @(posedge clk);
      t++;
    end
    check(32'(t), 32'(exp));
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h9f4a_503a));
    strap <= 3'($urandom);
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    repeat (8) @(posedge clk);
    wr(lcd_ram_pkg::SubOffs, {29'h0, strap});
    for (int c = 0; c < 6; c++)
    begin
      m = c % 4;
      n = (m == 0) ? 1 : m + 1;
      ofs = (c > 3) ? 2 : 0;
      p = int'($urandom % 30);
      b = 8'($urandom);
      wr(lcd_ram_pkg::CtrlOffs, {24'h0, c > 3, 5'h00, 2'(m)});
      wr(lcd_ram_pkg::PtrOffs, 32'(p));
      for (int i = 0; i < 8; i++)
      begin
        rdw(8'(lcd_ram_pkg::RamBase + 4 * (p + i)));
        old[i] = rd[3:0];
      end
      wr(lcd_ram_pkg::DataOffs, {24'h0, b});
      drain();
      for (int k = 0; k < 8; k++)
        old[k / n][ofs + k % n] = b[7 - k];
      for (int i = 0; i < 8; i++)
      begin
        rdw(8'(lcd_ram_pkg::RamBase + 4 * (p + i)));
        check(rd, {28'h0, old[i]});
      end
      rdw(lcd_ram_pkg::PtrOffs);
      check(rd, 32'(p + (8 + n - 1) / n));
    end
    $display("placement done");
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_0004);
    wr(lcd_ram_pkg::SubOffs, {29'h0, strap + 3'h1});
    wr(lcd_ram_pkg::PtrOffs, 32'h0000_0000);
    rdw(lcd_ram_pkg::RamBase);
    b = {~rd[0], 7'h7f};
    wr(lcd_ram_pkg::DataOffs, {24'h0, b});
    drain();
    rdw(lcd_ram_pkg::RamBase);
    check({31'h0, rd[0]}, {31'h0, ~b[7]});
    rdw(lcd_ram_pkg::PtrOffs);
    check(rd, 32'h0000_0008);
    wr(lcd_ram_pkg::SubOffs, {29'h0, strap});
    wr(lcd_ram_pkg::PtrOffs, 32'h0000_0000);
    wr(lcd_ram_pkg::DataOffs, 32'h0000_0000);
    wr(lcd_ram_pkg::SubOffs, {29'h0, strap - 3'h1});
    wr(lcd_ram_pkg::PtrOffs, 32'h0000_0024);
    wr(lcd_ram_pkg::DataOffs, 32'h0000_00ff);
    drain();
    rdw(lcd_ram_pkg::SubOffs);
    check(rd, {29'h0, strap});
    rdw(lcd_ram_pkg::PtrOffs);
    check(rd, 32'h0000_0004);
    for (int i = 0; i < 5; i++)
    begin
      rdw(8'(lcd_ram_pkg::RamBase + 4 * i));
      check({31'h0, rd[0]}, {31'h0, i < 4});
    end
    rdw(8'h14);
    check({31'h0, err}, 32'h0000_0001);
    wr(lcd_ram_pkg::RamBase, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("cascade done");
    b = 8'($urandom) | 8'h01;
    wr(lcd_ram_pkg::PtrOffs, 32'h0000_0000);
    wr(lcd_ram_pkg::DataOffs, {24'h0, b});
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_0084);
    wr(lcd_ram_pkg::PtrOffs, 32'h0000_0000);
    wr(lcd_ram_pkg::DataOffs, {24'h0, ~b});
    repeat (12) @(posedge clk);
    check({24'h0, segment[7:0]}, {24'h0, {<<{b}}});
    check({28'h0, backplane}, 32'h0000_0001);
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_0184);
    repeat (4) @(posedge clk);
    check({24'h0, segment[7:0]}, {24'h0, ~{<<{b}}});
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_0180);
    repeat (4) @(posedge clk);
    check(segment[31:0], 32'h0000_0000);
    $display("banks done");
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_0007);
    dwell(0, 720);
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_000f);
    dwell(0, 120);
    for (int r = 1; r < 4; r++)
      for (int s = 0; s < 2; s++)
      begin
        wr(lcd_ram_pkg::CtrlOffs, {26'h0, 2'(r), 1'(s), 3'h4});
        dwell(1, half_period(r, s));
      end
    wr(lcd_ram_pkg::CtrlOffs, 32'h0000_0054);
    dwell(1, 8);
    $display("timing done");
    final_report();
  end
endmodule

`default_nettype wire
